// ==== include/lhbp_pkg.sv ====
// package of constants and types for the lcd host bus port
package lhbp_pkg;

    // ************************************************************
    // host bus widths
    // ************************************************************
    localparam int unsigned DATA_W  = 16;            // host data path width
    localparam int unsigned ADDR_W  = 17;            // byte address width, 128K block
    localparam int unsigned WADDR_W = 16;            // word address width
    localparam int unsigned SYNC_W  = 44;            // pins passed through the synchroniser

    // ************************************************************
    // address map of the 128K byte block
    // ************************************************************
    localparam logic [16:0] BUF_BASE  = 17'h00000;   // display buffer starts at block base
    localparam logic [16:0] BUF_LIMIT = 17'h14000;   // first byte past the 80K buffer
    localparam logic [16:0] REG_BASE  = 17'h1FFE0;   // control registers, top 32 bytes

    // ************************************************************
    // configuration pin codes latched after reset
    // ************************************************************
    localparam logic [2:0] MODE_STROBE   = 3'h3;     // strobe mode, bus status as strobe
    localparam logic [2:0] MODE_SEPARATE = 3'h7;     // separate enables, needs status low
    localparam logic [1:0] CFG_SETTLE    = 2'h3;     // cycles until synchronised pins settle

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [15:0] DATA_RST = 16'h0000;     // data registers after reset
    localparam logic [16:0] ADDR_RST = 17'h00000;    // captured address after reset
    localparam logic [2:0]  MODE_RST = 3'h0;         // no bus mode until latched

    // host access sequencer states
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,                           // waiting for a host access
        ST_ARB   = 3'b001,                           // waiting for refresh to let go
        ST_ISSUE = 3'b010,                           // internal access strobe
        ST_READ  = 3'b011,                           // catching read data
        ST_DONE  = 3'b100                            // answer given, waiting for cycle end
    } lhbp_state_type;

endpackage

// ==== rtl/lhbp_host_port.sv ====
// host bus port of the lcd controller: strobe and separate-enable modes
`timescale 1ns/1ns
`default_nettype none

module lhbp_host_port (
    input  wire logic        core_clk_in,             // core clock, 20 MHz
    input  wire logic        sys_rst_in,              // async reset, active high
    input  wire logic        host_bus_clock_in,       // host bus clock, sampled
    input  wire logic        chip_sel_n_in,           // chip select, active low
    input  wire logic        bus_status_n_in,         // bus status / address strobe
    input  wire logic        rd_wr_n_in,              // direction or high read enable
    input  wire logic        read_en_n_in,            // low byte read enable
    input  wire logic        low_byte_write_en_n_in,  // low byte write enable
    input  wire logic        high_byte_write_en_n_in, // high write enable or strobe
    input  wire logic [16:0] host_addr_in,            // host address, bit 0 may strobe
    input  wire logic [15:0] host_data_in,            // host data bus, sensed
    output logic      [15:0] host_data_out,           // host data bus, driven value
    output logic             host_data_oe_out,        // high while driving data
    output logic             wait_n_out,              // wait or acknowledge, active low
    output logic             wait_oe_out,             // high while driving wait
    input  wire logic  [2:0] mode_config_pin_in,      // bus mode straps
    input  wire logic        endian_select_pin_in,    // endian strap
    output logic             strobe_mode_out,         // strobe mode latched
    output logic             big_endian_out,          // big endian latched
    output logic             port_enabled_out,        // a supported mode latched
    input  wire logic        refresh_req_in,          // display refresh wants memory
    output logic             refresh_gnt_out,         // refresh may use memory
    output logic             mem_req_out,             // one cycle internal access
    output logic             mem_we_out,              // access is a write
    output logic             mem_reg_sel_out,         // access hits control registers
    output logic      [15:0] mem_addr_out,            // word address
    output logic       [1:0] mem_be_out,              // byte enables, bit 0 even byte
    output logic      [15:0] mem_wdata_out,           // write data, little endian lanes
    input  wire logic [15:0] mem_rdata_in             // read data, one cycle after request
);

    // ************************************************************
    // byte lane helpers
    // ************************************************************

    // swap bytes of a word for big endian hosts
    function automatic logic [15:0] swap_word(input logic [15:0] d, input logic big);
        swap_word = big ? {d[7:0], d[15:8]} : d;
    endfunction

    // swap the two lane enables the same way
    function automatic logic [1:0] swap_lanes(input logic [1:0] e, input logic big);
        swap_lanes = big ? {e[0], e[1]} : e;
    endfunction

    // ************************************************************
    // pin synchroniser
    // ************************************************************
    logic [43:0] pins_raw;                            // all pins from outside
    logic [43:0] sync1_q;                             // first stage, read by second only
    logic [43:0] sync2_q;                             // second stage, safe to use

    assign pins_raw = {endian_select_pin_in, mode_config_pin_in, host_data_in,
                       host_addr_in, host_bus_clock_in, high_byte_write_en_n_in,
                       low_byte_write_en_n_in, read_en_n_in, rd_wr_n_in,
                       bus_status_n_in, chip_sel_n_in};

    // two flops per pin; data is only captured after a host clock edge,
    // so per-bit skew has settled by then
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pins_raw;
            sync2_q <= sync1_q;
        end
    end

    logic        s_cs_n;                              // synced chip select
    logic        s_bs_n;                              // synced bus status
    logic        s_rdwr_n;                            // synced read/write
    logic        s_rd_n;                              // synced low read enable
    logic        s_lwe_n;                             // synced low write enable
    logic        s_hwe_n;                             // synced high write enable
    logic        s_hclk;                              // synced host clock
    logic [16:0] s_addr;                              // synced address
    logic [15:0] s_data;                              // synced data
    logic  [2:0] s_mode;                              // synced mode straps
    logic        s_endian;                            // synced endian strap

    assign {s_endian, s_mode, s_data, s_addr, s_hclk, s_hwe_n, s_lwe_n,
            s_rd_n, s_rdwr_n, s_bs_n, s_cs_n} = sync2_q;

    // ************************************************************
    // configuration latch
    // ************************************************************
    logic [1:0] cfg_cnt_q, cfg_cnt_d;                 // settle counter after reset
    logic       cfg_done_q, cfg_done_d;               // straps have been taken
    logic [2:0] mode_q, mode_d;                       // latched mode code
    logic       bs_cfg_q, bs_cfg_d;                   // latched bus status level
    logic       big_q, big_d;                         // latched byte order

    // straps are caught once, after reset release plus synchroniser delay
    always_comb begin
        cfg_cnt_d  = cfg_cnt_q;
        cfg_done_d = cfg_done_q;
        mode_d     = mode_q;
        bs_cfg_d   = bs_cfg_q;
        big_d      = big_q;
        if (!cfg_done_q) begin
            if (cfg_cnt_q == lhbp_pkg::CFG_SETTLE) begin
                cfg_done_d = 1'b1;
                mode_d     = s_mode;
                bs_cfg_d   = s_bs_n;
                big_d      = s_endian;
            end else begin
                cfg_cnt_d = cfg_cnt_q + 2'h1;
            end
        end
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            cfg_cnt_q  <= 2'h0;
            cfg_done_q <= 1'b0;
            mode_q     <= lhbp_pkg::MODE_RST;
            bs_cfg_q   <= 1'b0;
            big_q      <= 1'b0;
        end else begin
            cfg_cnt_q  <= cfg_cnt_d;
            cfg_done_q <= cfg_done_d;
            mode_q     <= mode_d;
            bs_cfg_q   <= bs_cfg_d;
            big_q      <= big_d;
        end
    end

    logic is_strobe;                                  // strobe mode in force
    logic is_sep;                                     // separate-enable mode in force

    assign is_strobe = cfg_done_q && (mode_q == lhbp_pkg::MODE_STROBE);
    // separate mode needs status strapped low
    assign is_sep    = cfg_done_q && (mode_q == lhbp_pkg::MODE_SEPARATE) && !bs_cfg_q;

    assign strobe_mode_out  = is_strobe;
    assign big_endian_out   = big_q;
    assign port_enabled_out = is_strobe || is_sep;

    // ************************************************************
    // host cycle decode
    // ************************************************************
    logic       hclk_prev_q;                          // host clock one cycle ago
    logic       hclk_rise;                            // host clock rising edge seen
    logic [1:0] wr_lanes;                             // write lanes, host order
    logic [1:0] rd_lanes;                             // read lanes, host order
    logic       host_write;                           // cycle is a write
    logic       host_active;                          // a host cycle is in progress

    assign hclk_rise = s_hclk && !hclk_prev_q;

    always_comb begin
        wr_lanes    = 2'b00;
        rd_lanes    = 2'b00;
        host_write  = 1'b0;
        host_active = 1'b0;
        if (is_strobe) begin
            // bit zero and high enable strobe lanes
            host_write = !s_rdwr_n;
            wr_lanes   = host_write ? {!s_hwe_n, !s_addr[0]} : 2'b00;
            rd_lanes   = host_write ? 2'b00 : {!s_hwe_n, !s_addr[0]};
            host_active = !s_cs_n && !s_bs_n && (wr_lanes != 2'b00 || rd_lanes != 2'b00);
        end else if (is_sep) begin
            wr_lanes    = {!s_hwe_n, !s_lwe_n};
            rd_lanes    = {!s_rdwr_n, !s_rd_n};
            host_write  = wr_lanes != 2'b00;
            host_active = !s_cs_n && (wr_lanes != 2'b00 || rd_lanes != 2'b00);
        end
    end

    // ************************************************************
    // access sequencer
    // ************************************************************
    lhbp_pkg::lhbp_state_type st_q, st_d;             // sequencer state
    logic [16:0] addr_q, addr_d;                      // captured byte address
    logic        wr_q, wr_d;                          // captured direction
    logic  [1:0] be_q, be_d;                          // captured lanes, memory order
    logic [15:0] wdata_q, wdata_d;                    // captured write data
    logic [15:0] rdata_q, rdata_d;                    // read data for the host
    logic        req_q, req_d;                        // internal access strobe
    logic        oe_q, oe_d;                          // data drive enable
    logic        wait_q, wait_d;                      // wait pin level
    logic        woe_q, woe_d;                        // wait pin drive enable
    logic        in_buf;                              // address inside display buffer
    logic        in_reg;                              // address inside register window

    // decode of the 128K block; the gap reads zero and drops writes
    assign in_buf = addr_q < lhbp_pkg::BUF_LIMIT;
    assign in_reg = addr_q >= lhbp_pkg::REG_BASE;

    always_comb begin
        st_d    = st_q;
        addr_d  = addr_q;
        wr_d    = wr_q;
        be_d    = be_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        req_d   = 1'b0;
        unique case (st_q)
            // a cycle is taken only on a host clock edge
            lhbp_pkg::ST_IDLE: begin
                if (host_active && hclk_rise) begin
                    addr_d  = {s_addr[16:1], 1'b0};
                    wr_d    = host_write;
                    // lanes follow the latched byte order
                    be_d    = swap_lanes(host_write ? wr_lanes : rd_lanes, big_q);
                    wdata_d = swap_word(s_data, big_q);
                    st_d    = lhbp_pkg::ST_ARB;
                end
            end
            // refresh keeps the memory while it asks
            lhbp_pkg::ST_ARB: begin
                if (!refresh_req_in) begin
                    req_d = in_buf || in_reg;
                    st_d  = lhbp_pkg::ST_ISSUE;
                end
            end
            // write is accepted once issued
            lhbp_pkg::ST_ISSUE: begin
                st_d = wr_q ? lhbp_pkg::ST_DONE : lhbp_pkg::ST_READ;
            end
            // only enabled lanes carry data back
            lhbp_pkg::ST_READ: begin
                rdata_d = (in_buf || in_reg) ?
                          swap_word(mem_rdata_in & {{8{be_q[1]}}, {8{be_q[0]}}}, big_q) :
                          lhbp_pkg::DATA_RST;
                st_d    = lhbp_pkg::ST_DONE;
            end
            // answer stands until the host ends its cycle
            lhbp_pkg::ST_DONE: begin
                if (!host_active) begin
                    st_d = lhbp_pkg::ST_IDLE;
                end
            end
            default: begin
                st_d = lhbp_pkg::ST_IDLE;
            end
        endcase

        // drive data only while selected and reading
        oe_d = (st_d == lhbp_pkg::ST_DONE) && !wr_q && !s_cs_n && (rd_lanes != 2'b00);

        // wait length follows arbitration, not a count
        if (is_strobe) begin
            // acknowledge style: low once data ready or taken
            wait_d = !(st_d == lhbp_pkg::ST_DONE);
        end else begin
            // low while the host must wait
            wait_d = !(host_active && st_d != lhbp_pkg::ST_DONE);
        end
        woe_d = !s_cs_n && (is_strobe || is_sep);
    end

    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            st_q        <= lhbp_pkg::ST_IDLE;
            addr_q      <= lhbp_pkg::ADDR_RST;
            wr_q        <= 1'b0;
            be_q        <= 2'b00;
            wdata_q     <= lhbp_pkg::DATA_RST;
            rdata_q     <= lhbp_pkg::DATA_RST;
            req_q       <= 1'b0;
            oe_q        <= 1'b0;
            wait_q      <= 1'b1;
            woe_q       <= 1'b0;
            hclk_prev_q <= 1'b0;
        end else begin
            st_q        <= st_d;
            addr_q      <= addr_d;
            wr_q        <= wr_d;
            be_q        <= be_d;
            wdata_q     <= wdata_d;
            rdata_q     <= rdata_d;
            req_q       <= req_d;
            oe_q        <= oe_d;
            wait_q      <= wait_d;
            woe_q       <= woe_d;
            hclk_prev_q <= s_hclk;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************

    // sixteen-bit path to registers and buffer
    assign mem_req_out      = req_q;
    assign mem_we_out       = wr_q;
    assign mem_reg_sel_out  = in_reg;
    assign mem_addr_out     = addr_q[16:1];
    assign mem_be_out       = be_q;
    assign mem_wdata_out    = wdata_q;
    // refresh owns memory except during a host strobe
    assign refresh_gnt_out  = refresh_req_in && (st_q != lhbp_pkg::ST_ISSUE);
    assign host_data_out    = rdata_q;
    assign host_data_oe_out = oe_q;
    assign wait_n_out       = wait_q;
    assign wait_oe_out      = woe_q;

endmodule

`default_nettype wire

// ==== bench/lhbp_host_port_assertions.sv ====
// concurrent checks on the pins of the lcd host bus port
`timescale 1ns/1ns
`default_nettype none
// ************************************
// port checker
// ************************************
module lhbp_host_port_assertions (
    input wire logic        core_clk_in,      // core clock
    input wire logic        sys_rst_in,       // async reset
    input wire logic        chip_sel_n_in,    // chip select
    input wire logic        host_data_oe_out, // data drive
    input wire logic        wait_n_out,       // wait pin
    input wire logic        wait_oe_out,      // wait drive
    input wire logic        strobe_mode_out,  // strobe mode
    input wire logic        port_enabled_out, // mode latched
    input wire logic        refresh_gnt_out,  // refresh grant
    input wire logic        mem_req_out,      // access pulse
    input wire logic        mem_we_out,       // write access
    input wire logic        mem_reg_sel_out,  // register hit
    input wire logic [15:0] mem_addr_out      // word address
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);
    property p_req_pulse; mem_req_out |=> !mem_req_out; endproperty
    a_req_pulse: assert property (p_req_pulse) else $error("access pulse too long");
    property p_req_gnt; mem_req_out |-> !refresh_gnt_out; endproperty
    a_req_gnt: assert property (p_req_gnt) else $error("refresh granted during access");
    property p_map;
        mem_req_out |-> (mem_reg_sel_out == (mem_addr_out >= 16'hFFF0))
                        && (mem_reg_sel_out || mem_addr_out < 16'hA000);
    endproperty
    a_map: assert property (p_map) else $error("access outside the mapped block");
    property p_wr_ack; mem_req_out && mem_we_out && strobe_mode_out |=> !wait_n_out; endproperty
    a_wr_ack: assert property (p_wr_ack) else $error("write not acknowledged");
    property p_rd_ack;
        mem_req_out && !mem_we_out && strobe_mode_out |=> wait_n_out ##1 !wait_n_out;
    endproperty
    a_rd_ack: assert property (p_rd_ack) else $error("read acknowledge misplaced");
    property p_sep_wait;
        mem_req_out && !strobe_mode_out |-> !wait_n_out ##1 (wait_n_out == mem_we_out);
    endproperty
    a_sep_wait: assert property (p_sep_wait) else $error("wait level wrong");
    property p_oe_idle; chip_sel_n_in [*4] |-> !host_data_oe_out; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("data driven while unselected");
    property p_oe_write; mem_req_out && mem_we_out |-> !host_data_oe_out; endproperty
    a_oe_write: assert property (p_oe_write) else $error("data driven during write");
    // wait only in a valid mode
    property p_wait_mode; wait_oe_out |-> port_enabled_out; endproperty
    a_wait_mode: assert property (p_wait_mode) else $error("wait driven in idle mode");
    c_write: cover property (mem_req_out && mem_we_out);
    c_sep_read: cover property (mem_req_out && !mem_we_out && !strobe_mode_out);
    c_reg: cover property (mem_req_out && mem_reg_sel_out);
endmodule
bind lhbp_host_port lhbp_host_port_assertions u_chk (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .chip_sel_n_in(chip_sel_n_in),
    .host_data_oe_out(host_data_oe_out), .wait_n_out(wait_n_out), .wait_oe_out(wait_oe_out),
    .strobe_mode_out(strobe_mode_out), .port_enabled_out(port_enabled_out),
    .refresh_gnt_out(refresh_gnt_out), .mem_req_out(mem_req_out), .mem_we_out(mem_we_out),
    .mem_reg_sel_out(mem_reg_sel_out), .mem_addr_out(mem_addr_out)
);
`default_nettype wire

// ==== bench/lhbp_host_model.sv ====
// host processor model driving the lcd host bus port pins
`timescale 1ns/1ns
`default_nettype none
// ************************************
// host bus master
// ************************************
module lhbp_host_model (
    input  wire logic        core_clk_in, // bench sampling clock
    output logic             hclk_out,    // host bus clock
    output logic             cs_n_out,    // chip select
    output logic             bs_n_out,    // address strobe or strap
    output logic             rdwr_n_out,  // direction or high read enable
    output logic             rd_n_out,    // low read enable
    output logic             we0_n_out,   // low write enable
    output logic             we1_n_out,   // high write enable or strobe
    output logic      [16:0] addr_out,    // byte address
    output wire logic [15:0] data_out,    // resolved data bus
    input  wire logic [15:0] dev_data_in, // device data value
    input  wire logic        dev_oe_in,   // device drives data
    input  wire logic        wait_n_in,   // wait or acknowledge
    input  wire logic        wait_oe_in   // wait pin driven
);
    logic        sep_q; // separate-enable mode
    logic        drv_q; // host drives data
    logic [15:0] wd_q;  // host write value
    int          timeouts = 0; // cycles that never got an answer
    initial begin
        hclk_out = 1'b0;
        forever #200 hclk_out = ~hclk_out;
    end
    // released bus shows the inverse so stale data never passes
    assign data_out = dev_oe_in ? dev_data_in : (drv_q ? wd_q : ~wd_q);
    task automatic idle();
        {cs_n_out, rdwr_n_out, rd_n_out, we0_n_out, we1_n_out, drv_q} = 6'h3E;
        bs_n_out = ~sep_q;
    endtask
    initial begin
        sep_q = 1'b0;
        wd_q = 16'h0000;
        addr_out = 17'h00000;
        idle();
    end
    task automatic access(input logic w, input logic [16:0] a, input logic [1:0] ln,
                          input logic [15:0] wd, output logic [15:0] rd);
        int n;
        @(negedge core_clk_in);
        n = 0;
        addr_out = sep_q ? a : {a[16:1], ~ln[0]};
        wd_q = wd;
        drv_q = w;
        rdwr_n_out = sep_q ? (w | ~ln[1]) : ~w;
        rd_n_out = ~(sep_q & ~w & ln[0]);
        we0_n_out = ~(sep_q & w & ln[0]);
        we1_n_out = ~(ln[1] & (w | ~sep_q));
        bs_n_out = 1'b0;
        cs_n_out = 1'b0;
        while (!(wait_oe_in === 1'b1 && wait_n_in === 1'b0) && n < 400) begin
            @(negedge core_clk_in);
            n++;
        end
        while (sep_q && wait_n_in !== 1'b1 && n < 400) begin
            @(negedge core_clk_in);
            n++;
        end
        // a cycle that hit the limit must not pass silently
        if (n >= 400) timeouts++;
        rd = data_out;
        idle();
        // let the port fall back to idle before the next cycle
        while (wait_oe_in !== 1'b0 && n < 800) begin
            @(negedge core_clk_in);
            n++;
        end
        repeat (4) @(negedge core_clk_in);
    endtask
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// self-checking bench for the lcd host bus port
`timescale 1ns/1ns
`default_nettype none
// ************************************
// bench top
// ************************************
module tb_top;
    logic        clk, rst, refr, endian;                    // clock, reset, refresh, strap
    logic  [2:0] mode;                                      // mode straps
    logic [15:0] mem_q [0:15];                              // memory behind the port
    logic [15:0] hd, dout, maddr, mwd, rdat;                // data paths
    logic        hclk, cs_n, bs_n, rdwr_n, rd_n, we0_n, we1_n; // host pins
    logic        doe, wn, woe, smode, bigend, pen, gnt, mreq, mwe, mreg; // outputs
    logic [16:0] haddr;                                     // host address
    logic  [1:0] mbe;                                       // byte enables
    int          mismatches, total_checks;                  // counters
    lhbp_host_port dut (.core_clk_in(clk), .sys_rst_in(rst), .host_bus_clock_in(hclk),
        .chip_sel_n_in(cs_n), .bus_status_n_in(bs_n), .rd_wr_n_in(rdwr_n), .read_en_n_in(rd_n),
        .low_byte_write_en_n_in(we0_n), .high_byte_write_en_n_in(we1_n), .host_addr_in(haddr),
        .host_data_in(hd), .host_data_out(dout), .host_data_oe_out(doe), .wait_n_out(wn),
        .wait_oe_out(woe), .mode_config_pin_in(mode), .endian_select_pin_in(endian),
        .strobe_mode_out(smode), .big_endian_out(bigend), .port_enabled_out(pen),
        .refresh_req_in(refr), .refresh_gnt_out(gnt), .mem_req_out(mreq), .mem_we_out(mwe),
        .mem_reg_sel_out(mreg), .mem_addr_out(maddr), .mem_be_out(mbe),
        .mem_wdata_out(mwd), .mem_rdata_in(rdat));
    lhbp_host_model host (.core_clk_in(clk), .hclk_out(hclk), .cs_n_out(cs_n),
        .bs_n_out(bs_n), .rdwr_n_out(rdwr_n), .rd_n_out(rd_n), .we0_n_out(we0_n),
        .we1_n_out(we1_n), .addr_out(haddr), .data_out(hd), .dev_data_in(dout),
        .dev_oe_in(doe), .wait_n_in(wn), .wait_oe_in(woe));
    // combinational read keeps the answer valid from capture onward
    assign rdat = mem_q[maddr[3:0]];
    always @(posedge clk) begin
        if (mreq && mwe && mbe[0]) mem_q[maddr[3:0]][7:0] <= mwd[7:0];
        if (mreq && mwe && mbe[1]) mem_q[maddr[3:0]][15:8] <= mwd[15:8];
    end
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [16:0] a, input logic [1:0] ln, input logic [15:0] d);
        logic [15:0] v;
        host.access(1'b1, a, ln, d, v);
    endtask
    task automatic rd(input logic [16:0] a, input logic [1:0] ln, input logic [15:0] exp);
        logic [15:0] v;
        host.access(1'b0, a, ln, 16'h0000, v);
        check(v, exp);
    endtask
    // straps held through reset and the settle time
    task automatic restart(input logic [2:0] m, input logic e, input logic s);
        @(negedge clk);
        rst = 1'b1;
        mode = m;
        endian = e;
        host.sep_q = s;
        host.idle();
        repeat (10) @(negedge clk);
        rst = 1'b0;
        repeat (12) @(negedge clk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // watchdog, far beyond the expected run length
    initial begin
        #500000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        {rst, refr, endian, mode, mismatches, total_checks} = '0;
        rst = 1'b1;
        for (int i = 0; i < 16; i++) mem_q[i] = 16'h0000;
        restart(3'h3, 1'b0, 1'b0);
        check(16'(smode), 16'h1);
        check(16'(bigend), 16'h0);
        wr(17'h00004, 2'b11, 16'hA55A);
        check(mem_q[2], 16'hA55A);
        wr(17'h00004, 2'b01, 16'h0000);
        rd(17'h00004, 2'b11, 16'hA500);
        wr(17'h1FFE2, 2'b11, 16'h1234);
        rd(17'h1FFE2, 2'b11, 16'h1234);
        check(mem_q[1], 16'h1234);
        wr(17'h15000, 2'b11, 16'hFFFF);
        check(mem_q[0], 16'h0000);
        rd(17'h15000, 2'b11, 16'h0000);
        refr = 1'b1;
        fork
            wr(17'h00006, 2'b11, 16'h0F0F);
            begin
                repeat (40) @(negedge clk);
                check(mem_q[3], 16'h0000);
                check(16'(gnt), 16'h1);
                refr = 1'b0;
            end
        join
        check(mem_q[3], 16'h0F0F);
        restart(3'h7, 1'b1, 1'b1);
        check(16'(bigend), 16'h1);
        check(16'(smode), 16'h0);
        wr(17'h00020, 2'b11, 16'h1234);
        check(mem_q[0], 16'h3412);
        rd(17'h00020, 2'b11, 16'h1234);
        rd(17'h00020, 2'b01, 16'h0034);
        wr(17'h00020, 2'b10, 16'hAB00);
        check(mem_q[0], 16'h34AB);
        restart(3'h7, 1'b0, 1'b0);
        check(16'(pen), 16'h0);
        restart(3'h0, 1'b0, 1'b1);
        check(16'(pen), 16'h0);
        host.cs_n_out = 1'b0;
        host.rd_n_out = 1'b0;
        repeat (20) @(negedge clk);
        check(16'(woe), 16'h0);
        check(16'(doe), 16'h0);
        host.idle();
        check(host.timeouts[15:0], 16'h0000);
        report_and_stop();
    end
endmodule
`default_nettype wire
